/* pmic_mode_pkg.sv */
package pmic_mode_pkg;
   // register word indices; byte address is four times the index
   localparam logic [5:0] IDX_POWER_CTRL = 6'h1b;
   localparam logic [5:0] IDX_MODE_CTRL  = 6'h1c;
   localparam logic [5:0] IDX_SLEEP_KEEP = 6'h1d;
   localparam logic [5:0] IDX_STATUS     = 6'h1e;
   localparam logic [5:0] IDX_FAULT_MASK = 6'h1f;
   localparam logic [5:0] IDX_ON_BASE    = 6'h20;
   localparam logic [5:0] IDX_STBY_BASE  = 6'h28;
   localparam logic [5:0] IDX_OFF_BASE   = 6'h30;

   // regulator layout
   localparam int NBUCK  = 7;
   localparam int NCORE  = 3;
   localparam int SP_W   = 7;
   localparam int CORE_W = 6;
   localparam int NFAULT = 8;

   // field positions
   localparam int BIT_STBY_INV = 6;
   localparam int HOLD_HI      = 5;
   localparam int HOLD_LO      = 4;
   localparam int BIT_PB_STYLE = 0;
   localparam int BIT_LP_EN    = 1;

   // reset values
   localparam logic [7:0]      POWER_CTRL_RST = 8'h10;
   localparam logic [1:0]      MODE_CTRL_RST  = 2'h0;
   localparam logic [SP_W-1:0] SP_RST         = 7'h20;
   localparam logic [NBUCK-1:0] KEEP_RST      = 7'h00;
   localparam logic [NFAULT-1:0] MASK_RST     = 8'hff;

   // timing
   localparam longint CLK_HZ        = 100_000_000;
   localparam longint SLOW_HZ       = 32_768;
   localparam int     SLOW_DIV      = int'(CLK_HZ / SLOW_HZ);
   localparam int     LONG_PRESS_MS = 4000;
   localparam int     LONG_PRESS_CYC = int'(longint'(LONG_PRESS_MS) * (CLK_HZ / 1000));
   localparam int     STBY_SYNC_TICKS = 3;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // operating states, gray along off-on-standby and on-sleep
   typedef enum logic [2:0] {
      ST_OFF     = 3'b000,
      ST_ON      = 3'b001,
      ST_STANDBY = 3'b011,
      ST_SLEEP   = 3'b101,
      ST_COIN    = 3'b100
   } mode_e;
endpackage

/* pmic_power_mode_controller.sv */
`timescale 1ns/1ps
// Summary of operation
// - five states with defined entries and exits
// - powering up needs supply above rising threshold
// - no port in coin cell; interrupt in three states
// - turn-on enters on, processor reset high
// - turn-off with no keep bits, or thermal, goes off, reset low
// - qualified standby enters and leaves standby
// - standby setpoints mirror on setpoints at power-up
// - standby control is pin xor invert bit
// - standby pin only acts in on and standby states
// - invert bit is bit 6 of 0x1B
// - hold-off codes zero to three slow periods
// - nonzero hold-off postpones the standby response
// - three extra slow cycles synchronise standby
// - hold-off field is bits 5:4 of 0x1B
// - sleep entry by keep bits, button exits
// - sleep uses off setpoints, core six bits
// - sleep settings held until next turn-on
// - unmasked faults drive interrupt during sleep
// - coin cell ignores turn-on, goes off on supply
// - button style selects level or falling edge
// - supply below falling threshold goes coin cell
module pmic_power_mode_controller
   import pmic_mode_pkg::*;
#(
   parameter int LONG_PRESS_CYCLES = LONG_PRESS_CYC
) (
   input  wire logic                    clock,
   input  wire logic                    reset_n,
   input  wire logic [7:0]              s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [7:0]              s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready,
   input  wire logic                    standbyPin,
   input  wire logic                    power_button_in,
   input  wire logic                    supplyAboveThreshold,
   input  wire logic                    thermalShutdown,
   input  wire logic [NFAULT-1:0]       faultEvent,
   output logic                         processor_reset_out_n,
   output logic                         interrupt_out_n,
   output logic                         serialPortActive,
   output logic [NBUCK*SP_W-1:0]        regulatorSetpoint,
   output logic [NBUCK-1:0]             regulatorEnable
);
   localparam int NPIN = NFAULT + 4;

   logic [1:0]            rstSync;
   logic                  rstN;
   logic [NPIN-1:0]       pinRaw, s1, s2, s3, pinLevel;
   logic                  stbyLevel, pbLevel, vinOk, thermal;
   logic [NFAULT-1:0]     faultLevel;
   logic [7:0]            powerCtrl;
   logic [1:0]            modeCtrl;
   logic [NBUCK-1:0]      sleepKeep, keepHeld;
   logic [NFAULT-1:0]     faultMask;
   logic [SP_W-1:0]       onSp [NBUCK];
   logic [SP_W-1:0]       stbySp [NBUCK];
   logic [SP_W-1:0]       offSp [NBUCK];
   logic [SP_W-1:0]       sleepSp [NBUCK];
   logic                  mirrorActive;
   mode_e                 state, next_state;
   logic [11:0]           slowCount;
   logic                  slowTick;
   logic [STBY_SYNC_TICKS-1:0] stbyStage;
   logic [1:0]            holdCount;
   logic                  stbyQual;
   logic                  pbPrev;
   logic [28:0]           pressCount;
   logic                  longPress, turnOn, turnOff, anyKeep;
   logic [7:0]            awAddr;
   logic [31:0]           wData;
   logic [3:0]            wStrb;
   logic                  awHeld, wHeld, doWrite;
   logic [5:0]            wIdx, rIdx;
   logic [31:0]           readWord;
   logic                  readHit;

   ////////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstN = rstSync[1];

   // pins are asynchronous: three flops, accept once stages two and three agree
   assign pinRaw = {faultEvent, thermalShutdown, supplyAboveThreshold, power_button_in,
                    standbyPin};
   genvar g;
   for (g = 0; g < NPIN; g++) begin : g_pin
      always_ff @(posedge clock or negedge rstN) begin
         if (!rstN) begin
            s1[g]       <= (g == 2);
            s2[g]       <= (g == 2);
            s3[g]       <= (g == 2);
            pinLevel[g] <= (g == 2); // supply idles valid: no false coin cell trip after reset
         end else begin
            s1[g] <= pinRaw[g];
            s2[g] <= s1[g];
            s3[g] <= s2[g];
            if (s2[g] == s3[g]) begin
               pinLevel[g] <= s3[g];
            end
         end
      end
   end
   assign stbyLevel  = pinLevel[0];
   assign pbLevel    = pinLevel[1];
   assign vinOk      = pinLevel[2];
   assign thermal    = pinLevel[3];
   assign faultLevel = pinLevel[NPIN-1:4];

   ////////////////////////////////////////////////////////////////////////////
   // 32 kHz tick from the system clock; truncated divide runs slightly fast
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         slowCount <= 12'h000;
         slowTick  <= 1'b0;
      end else begin
         slowTick <= (slowCount == 12'(SLOW_DIV - 1));
         if (slowCount == 12'(SLOW_DIV - 1)) begin
            slowCount <= 12'h000;
         end else begin
            slowCount <= slowCount + 12'h001;
         end
      end
   end

   // standby path: polarity decode then slow-clock stages then hold-off
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         stbyStage <= '0;
         holdCount <= 2'h0;
         stbyQual  <= 1'b0;
      end else if (slowTick) begin
         stbyStage <= {stbyStage[STBY_SYNC_TICKS-2:0], stbyLevel ^ powerCtrl[BIT_STBY_INV]};
         if (stbyStage[STBY_SYNC_TICKS-1] == stbyQual) begin
            holdCount <= 2'h0;
         end else if (holdCount >= powerCtrl[HOLD_HI:HOLD_LO]) begin
            stbyQual  <= stbyStage[STBY_SYNC_TICKS-1];
            holdCount <= 2'h0;
         end else begin
            holdCount <= holdCount + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power button: falling edge and long-press timer
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         pbPrev     <= 1'b0;
         pressCount <= 29'h0;
      end else begin
         pbPrev <= pbLevel;
         if (pbLevel) begin
            pressCount <= 29'h0;
         end else if (pressCount != 29'(LONG_PRESS_CYCLES)) begin
            pressCount <= pressCount + 29'h1;
         end
      end
   end
   assign longPress = (pressCount == 29'(LONG_PRESS_CYCLES));
   assign anyKeep   = |sleepKeep;

   // level enable or falling edge trigger
   always_comb begin
      if (modeCtrl[BIT_PB_STYLE]) begin
         turnOn  = pbPrev && !pbLevel;
         turnOff = longPress && modeCtrl[BIT_LP_EN];
      end else begin
         turnOn  = pbLevel;
         turnOff = !pbLevel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operating state transitions
   always_comb begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (!vinOk) begin
               next_state = ST_COIN;
            end else if (turnOn && !thermal) begin
               next_state = ST_ON;
            end
         end
         ST_COIN: begin
            if (vinOk) begin
               next_state = ST_OFF;
            end
         end
         ST_ON, ST_STANDBY: begin
            if (!vinOk) begin
               next_state = ST_COIN;
            end else if (thermal) begin
               next_state = ST_OFF;
            end else if (turnOff) begin
               next_state = anyKeep ? ST_SLEEP : ST_OFF;
            end else if (state == ST_ON && stbyQual) begin
               next_state = ST_STANDBY;
            end else if (state == ST_STANDBY && !stbyQual) begin
               next_state = ST_ON;
            end
         end
         ST_SLEEP: begin
            if (!vinOk) begin
               next_state = ST_COIN;
            end else if (thermal) begin
               next_state = ST_OFF;
            end else if (turnOn) begin
               next_state = ST_ON;
            end
         end
         default: next_state = ST_OFF;
      endcase
   end

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         state <= ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // pin outputs by state
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         processor_reset_out_n <= 1'b0;
         interrupt_out_n       <= 1'b1;
         serialPortActive      <= 1'b0;
      end else begin
         // reset low in off and coin
         processor_reset_out_n <= (state == ST_ON) || (state == ST_STANDBY) ||
                                  (state == ST_SLEEP);
         interrupt_out_n <= !(((state == ST_ON) || (state == ST_STANDBY) ||
                               (state == ST_SLEEP)) && |(faultLevel & ~faultMask));
         serialPortActive <= (state != ST_COIN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-regulator set point and enable
   for (g = 0; g < NBUCK; g++) begin : g_reg
      always_ff @(posedge clock or negedge rstN) begin
         if (!rstN) begin
            sleepSp[g]     <= '0;
            keepHeld[g]    <= 1'b0;
            regulatorSetpoint[g*SP_W +: SP_W] <= '0;
            regulatorEnable[g] <= 1'b0;
         end else begin
            if (next_state == ST_SLEEP && state != ST_SLEEP) begin
               sleepSp[g]  <= (g < NCORE) ? {1'b0, offSp[g][CORE_W-1:0]} : offSp[g];
               keepHeld[g] <= sleepKeep[g];
            end
            case (state)
               ST_ON: begin
                  regulatorSetpoint[g*SP_W +: SP_W] <= onSp[g];
                  regulatorEnable[g] <= 1'b1;
               end
               ST_STANDBY: begin
                  regulatorSetpoint[g*SP_W +: SP_W] <= stbySp[g];
                  regulatorEnable[g] <= 1'b1;
               end
               ST_SLEEP: begin
                  // cleared keep bit turns it off
                  regulatorSetpoint[g*SP_W +: SP_W] <= sleepSp[g];
                  regulatorEnable[g] <= keepHeld[g];
               end
               default: begin
                  regulatorSetpoint[g*SP_W +: SP_W] <= '0;
                  regulatorEnable[g] <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi write channels: address and data taken in either order
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld && !s_axi_bvalid;
   assign doWrite       = awHeld && wHeld && !s_axi_bvalid;
   assign wIdx          = awAddr[7:2];

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         awHeld       <= 1'b0;
         wHeld        <= 1'b0;
         awAddr       <= 8'h00;
         wData        <= 32'h0;
         wStrb        <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (readHitW(wIdx) && state != ST_COIN) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   function automatic logic readHitW(input logic [5:0] idx);
      readHitW = (idx >= IDX_POWER_CTRL && idx <= IDX_FAULT_MASK) ||
                 (idx >= IDX_ON_BASE && idx < IDX_OFF_BASE + 6'(NBUCK)) &&
                 (idx[2:0] < 3'(NBUCK));
   endfunction

   // register storage; byte lane 0 carries every field, bus is dead in coin cell
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         powerCtrl    <= POWER_CTRL_RST;
         modeCtrl     <= MODE_CTRL_RST;
         sleepKeep    <= KEEP_RST;
         faultMask    <= MASK_RST;
         mirrorActive <= 1'b1;
         for (int i = 0; i < NBUCK; i++) begin
            onSp[i]   <= SP_RST;
            stbySp[i] <= SP_RST;
            offSp[i]  <= SP_RST;
         end
      end else if (doWrite && wStrb[0] && state != ST_COIN) begin
         if (wIdx == IDX_POWER_CTRL) begin
            powerCtrl <= wData[7:0] & 8'h70;
         end
         if (wIdx == IDX_MODE_CTRL) begin
            modeCtrl <= wData[1:0];
         end
         if (wIdx == IDX_SLEEP_KEEP) begin
            sleepKeep <= wData[NBUCK-1:0];
         end
         if (wIdx == IDX_FAULT_MASK) begin
            faultMask <= wData[NFAULT-1:0];
         end
         for (int i = 0; i < NBUCK; i++) begin
            if (wIdx == IDX_ON_BASE + 6'(i)) begin
               onSp[i] <= wData[SP_W-1:0];
               if (mirrorActive) begin
                  stbySp[i] <= wData[SP_W-1:0];
               end
            end
            if (wIdx == IDX_STBY_BASE + 6'(i)) begin
               stbySp[i]    <= wData[SP_W-1:0];
               mirrorActive <= 1'b0;
            end
            if (wIdx == IDX_OFF_BASE + 6'(i)) begin
               offSp[i] <= wData[SP_W-1:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read decode
   assign rIdx = s_axi_araddr[7:2];
   always_comb begin
      readWord = 32'h0;
      readHit  = readHitW(rIdx);
      case (rIdx)
         IDX_POWER_CTRL: readWord = {24'h0, powerCtrl};
         IDX_MODE_CTRL:  readWord = {30'h0, modeCtrl};
         IDX_SLEEP_KEEP: readWord = {25'h0, sleepKeep};
         IDX_STATUS:     readWord = {26'h0, vinOk, stbyQual, mirrorActive, state};
         IDX_FAULT_MASK: readWord = {24'h0, faultMask};
         default: begin
            for (int i = 0; i < NBUCK; i++) begin
               if (rIdx == IDX_ON_BASE + 6'(i)) readWord = {25'h0, onSp[i]};
               if (rIdx == IDX_STBY_BASE + 6'(i)) readWord = {25'h0, stbySp[i]};
               if (rIdx == IDX_OFF_BASE + 6'(i)) readWord = {25'h0, offSp[i]};
            end
         end
      endcase
   end

   // read answer one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= (readHit && state != ST_COIN) ? readWord : 32'h0;
         s_axi_rresp  <= (readHit && state != ST_COIN) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

/* pmic_host_model.sv */
`timescale 1ns/1ps
module pmic_host_model (
   input  wire logic clock,
   input  wire logic standbyReq,
   input  wire logic buttonReq,
   output logic      standbyPin = 1'b0,
   output logic      power_button_in = 1'b0
);
   // polarity before setpoints
   // pins move only after an edge, as a processor gpio would; the bench sets the
   // invert bit before it reprograms standby setpoints
   always_ff @(posedge clock) begin
      standbyPin <= standbyReq;
      power_button_in <= buttonReq;
   end
endmodule

/* pmic_power_mode_controller_asserts.sv */
`timescale 1ns/1ps
module pmic_mode_checker
   import pmic_mode_pkg::*;
(
   input wire logic                  clock,
   input wire logic                  reset_n,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic                  s_axi_rvalid,
   input wire logic [1:0]            s_axi_rresp,
   input wire logic                  supplyAboveThreshold,
   input wire logic                  thermalShutdown,
   input wire logic                  processor_reset_out_n,
   input wire logic                  interrupt_out_n,
   input wire logic                  serialPortActive,
   input wire logic [NBUCK*SP_W-1:0] regulatorSetpoint,
   input wire logic [NBUCK-1:0]      regulatorEnable
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////
   // long steady levels, so synchroniser lag never trips the checks
   sequence s_coin; !serialPortActive [*4]; endsequence
   sequence s_vinLow; !supplyAboveThreshold [*8]; endsequence
   sequence s_hot; thermalShutdown [*8]; endsequence
   property p_coinReset; !serialPortActive |-> !processor_reset_out_n; endproperty
   property p_vinLow; s_vinLow |-> ##[0:6] !serialPortActive; endproperty
   property p_hot; s_hot |-> ##[0:6] !processor_reset_out_n; endproperty
   property p_offIdle;
      !processor_reset_out_n [*2] |-> regulatorEnable == 7'h00 && interrupt_out_n;
   endproperty
   property p_sleepCore;
      processor_reset_out_n && regulatorEnable != 7'h7f
         |-> !(regulatorSetpoint[6] | regulatorSetpoint[13] | regulatorSetpoint[20]);
   endproperty
   property p_rAns; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   property p_bDone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   property p_coinErr; s_coin ##0 $rose(s_axi_rvalid) |-> s_axi_rresp == RESP_SLVERR; endproperty
   ////////////////////////////////////////////////////////////////////////////
   a_coinReset: assert property (p_coinReset)
      else $error("reset out high in coin cell");
   a_vinLow: assert property (p_vinLow)
      else $error("low supply did not reach coin cell");
   a_hot: assert property (p_hot)
      else $error("thermal event did not power off");
   a_offIdle: assert property (p_offIdle)
      else $error("outputs active while off");
   a_sleepCore: assert property (p_sleepCore)
      else $error("core setpoint wider than six bits");
   a_rAns: assert property (p_rAns)
      else $error("read not answered next cycle");
   a_bDone: assert property (p_bDone)
      else $error("write response not cleared");
   a_busy: assert property (p_busy)
      else $error("write taken during response");
   a_coinErr: assert property (p_coinErr)
      else $error("read accepted in coin cell");
endmodule
bind pmic_power_mode_controller pmic_mode_checker chk_u (.clock, .reset_n, .s_axi_awready,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rresp, .supplyAboveThreshold, .thermalShutdown, .processor_reset_out_n,
   .interrupt_out_n, .serialPortActive, .regulatorSetpoint, .regulatorEnable);

/* tb_pmic_power_mode_controller.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin errCount++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_pmic_power_mode_controller
   import pmic_mode_pkg::*;
;
   logic              clock = 1'b0, reset_n = 1'b0, stbyReq = 1'b0, btnReq = 1'b0;
   logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]        s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]       s_axi_wdata = '0, s_axi_rdata, seed = 32'h1e96;
   logic              supplyAboveThreshold = 1'b1, thermalShutdown = 1'b0;
   logic [NFAULT-1:0] faultEvent = '0;
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic              standbyPin, power_button_in, processor_reset_out_n;
   logic              interrupt_out_n, serialPortActive;
   logic [48:0]       regulatorSetpoint;
   logic [6:0]        regulatorEnable, onVal, stVal, off0, off3;
   int                errCount = 0, checksDone = 0, n;

   // long press shortened so the off path fits the run
   pmic_power_mode_controller #(.LONG_PRESS_CYCLES(50)) dut_u (.clock, .reset_n,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .standbyPin, .power_button_in, .supplyAboveThreshold, .thermalShutdown, .faultEvent,
      .processor_reset_out_n, .interrupt_out_n, .serialPortActive, .regulatorSetpoint,
      .regulatorEnable);
   pmic_host_model host_u (.clock, .standbyReq(stbyReq), .buttonReq(btnReq), .standbyPin,
      .power_button_in);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   // sleep setpoint as seen at the pins: core bucks keep six bits
   function automatic logic [6:0] sleepSp(input int b, input logic [6:0] v);
      return (b < NCORE) ? {1'b0, v[CORE_W-1:0]} : v;
   endfunction
   // sync ticks plus hold-off, with a tick of phase slack either side
   function automatic logic inWin(input int c, input int hd);
      return c >= (2 + hd) * SLOW_DIV && c <= (5 + hd) * SLOW_DIV;
   endfunction
   task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [1:0] er);
      logic a, w, b;
      logic [1:0] r;
      @(posedge clock);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge clock);
         a = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         b = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clock);
         if (a) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      `CHK(r, er)
   endtask
   task automatic rd(input logic [5:0] i, input logic [31:0] ed, input logic [1:0] er);
      logic a, v;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge clock);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      v = 1'b0;
      while (!v) begin
         @(negedge clock);
         a = s_axi_arvalid & s_axi_arready;
         v = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clock);
         if (a) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      `CHK(d, ed)
      `CHK(r, er)
   endtask
   // pins need about six clocks through synchronisers and state
   task automatic settle;
      repeat (12) @(negedge clock);
   endtask
   task automatic waitSp(input logic [6:0] v);
      n = 0;
      while (regulatorSetpoint[6:0] !== v && n < 30000) begin
         @(negedge clock);
         n++;
      end
   endtask
   task automatic close_out;
      $display("errors %0d checks %0d", errCount, checksDone);
      if (errCount == 0 && checksDone > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #5 clock = ~clock;
   end
   // two slow-clock standby waits dominate the run
   initial begin
      #800_000;
      errCount++;
      close_out();
   end
   initial begin
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
      repeat (4) @(posedge clock);
      seed = xs(seed);
      onVal = seed[6:0];
      stVal = onVal ^ 7'h55;
      seed = xs(seed);
      off0 = seed[6:0] | 7'h40;
      off3 = seed[13:7];
      rd(IDX_POWER_CTRL, 32'h1 << HOLD_LO, RESP_OKAY);
      rd(IDX_FAULT_MASK, 32'hff, RESP_OKAY);
      rd(6'h00, 32'h0, RESP_SLVERR);
      wr(IDX_ON_BASE, {25'h0, onVal}, RESP_OKAY);
      rd(IDX_STBY_BASE, {25'h0, onVal}, RESP_OKAY);
      btnReq <= 1'b1;
      settle();
      `CHK(processor_reset_out_n, 1'b1)
      `CHK(regulatorEnable, 7'h7f)
      `CHK(regulatorSetpoint[6:0], onVal)
      wr(IDX_POWER_CTRL, 32'h1 << BIT_STBY_INV, RESP_OKAY);
      wr(IDX_STBY_BASE, {25'h0, stVal}, RESP_OKAY);
      waitSp(stVal);
      `CHK(inWin(n, 0), 1'b1)
      wr(IDX_POWER_CTRL, 32'h70, RESP_OKAY);
      stbyReq <= 1'b1;
      waitSp(onVal);
      `CHK(inWin(n, 3), 1'b1)
      wr(IDX_OFF_BASE, {25'h0, off0}, RESP_OKAY);
      wr(IDX_OFF_BASE + 6'h3, {25'h0, off3}, RESP_OKAY);
      wr(IDX_SLEEP_KEEP, 32'h09, RESP_OKAY);
      btnReq <= 1'b0;
      settle();
      `CHK(regulatorEnable, 7'h09)
      `CHK(regulatorSetpoint[6:0], sleepSp(0, off0))
      `CHK(regulatorSetpoint[27:21], sleepSp(3, off3))
      wr(IDX_OFF_BASE, 32'h0, RESP_OKAY);
      wr(IDX_FAULT_MASK, 32'hfe, RESP_OKAY);
      faultEvent <= 8'h01;
      settle();
      `CHK(regulatorSetpoint[6:0], sleepSp(0, off0))
      `CHK(interrupt_out_n, 1'b0)
      @(posedge clock);
      faultEvent <= 8'h02;
      settle();
      `CHK(interrupt_out_n, 1'b1)
      @(posedge clock);
      btnReq <= 1'b1;
      settle();
      `CHK(regulatorEnable, 7'h7f)
      @(posedge clock);
      thermalShutdown <= 1'b1;
      settle();
      `CHK(processor_reset_out_n, 1'b0)
      @(posedge clock);
      btnReq <= 1'b0;
      thermalShutdown <= 1'b0;
      supplyAboveThreshold <= 1'b0;
      settle();
      `CHK(serialPortActive, 1'b0)
      rd(IDX_POWER_CTRL, 32'h0, RESP_SLVERR);
      btnReq <= 1'b1;
      settle();
      `CHK(processor_reset_out_n, 1'b0)
      @(posedge clock);
      btnReq <= 1'b0;
      supplyAboveThreshold <= 1'b1;
      settle();
      `CHK(serialPortActive, 1'b1)
      wr(IDX_SLEEP_KEEP, 32'h0, RESP_OKAY);
      wr(IDX_MODE_CTRL, 32'h3, RESP_OKAY);
      btnReq <= 1'b1;
      settle();
      `CHK(processor_reset_out_n, 1'b0)
      @(posedge clock);
      btnReq <= 1'b0;
      settle();
      `CHK(processor_reset_out_n, 1'b1)
      repeat (60) @(negedge clock);
      `CHK(processor_reset_out_n, 1'b0)
      close_out();
   end
endmodule
